// >>> inc/srsq_cfg.svh
// Purpose: Timing counts and widths for the start-up reset sequencer.
// Assumes: The system clock runs at 50 MHz, a period of 20 ns.
// Notes: The power-down and settle counts are derived from times in their own unit; the rest are given in cycles.
`ifndef SRSQ_CFG_SVH
`define SRSQ_CFG_SVH
`define SRSQ_CLK_PERIOD_NS 20
`define SRSQ_PDN_LOW_MIN_NS 200
`define SRSQ_PDN_LOW_CYC ((`SRSQ_PDN_LOW_MIN_NS / `SRSQ_CLK_PERIOD_NS) + 1)
`define SRSQ_HOST_SETTLE_MS 100
`define SRSQ_HOST_SETTLE_CYC (`SRSQ_HOST_SETTLE_MS * 1000000 / `SRSQ_CLK_PERIOD_NS)
`define SRSQ_POR_CYC 16
`define SRSQ_CAL_CYC 64
`define SRSQ_LOCK_CYC 32
`define SRSQ_CH_TMO_DEF 16'h0100
`define SRSQ_CH_NUM 8
`define SRSQ_TMO_W 16
`endif

// >>> inc/srsq_pkg.sv
// Purpose: Types shared by both ends of the start-up reset sequencer.
// Assumes: Nothing beyond the cfg header.
// Notes: Device sequence states.
package srsq_pkg;
  typedef enum logic [2:0] {
    SRSQ_OFF,
    SRSQ_POR,
    SRSQ_XO_WAIT,
    SRSQ_CAL,
    SRSQ_LOCK,
    SRSQ_RUN
  } srsq_state_t;
endpackage

// >>> inc/srsq_if.sv
// Purpose: Link between the host power manager and the sequencer device.
// Assumes: One shared clock; the power-down line is a plain wire.
// Notes: The device samples power_down_in_n through two flip-flops.
`timescale 1ns/10ps
interface srsq_if;
  logic power_down_in_n;
  logic soft_reset;
  logic xo_stable;
  logic serial_enable;
  logic pll_locked;
  modport dev
  (
    input power_down_in_n,
    input soft_reset,
    output xo_stable,
    output serial_enable,
    output pll_locked
  );
  modport host
  (
    output power_down_in_n,
    output soft_reset,
    input xo_stable,
    input serial_enable,
    input pll_locked
  );
endinterface

// >>> design/srsq_device.sv
// Purpose: Device end: power-on reset, calibration and channel release.
// Assumes: Supply comparators arrive as asynchronous levels.
// Notes: Channel timeouts run separately per channel.
//
// How it works
// - Absent channel supply keeps channel reset, muted.
// - After supply rises, timeout expires, then unmute.
// - Power-down low disables device and serial port.
// - Power-down rising edge starts reset then start-up.
// - Host holds power-down low over 200 ns.
// - Reset held until core supplies and pin good.
// - Host delays release until split supplies settle.
// - Host holds low for slow or odd ramps.
// - Calibration uses the crystal reference, waits stable.
// - Soft reset reruns calibration and PLL start-up.
`timescale 1ns/10ps
`include "srsq_cfg.svh"
module srsq_device #(
  parameter int CH_NUM = `SRSQ_CH_NUM,
  parameter logic [`SRSQ_TMO_W-1:0] CH_TMO = `SRSQ_CH_TMO_DEF
)
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Link to the host.
  srsq_if.dev lnk,
  // Analog comparator levels and the start-up mode strap.
  input wire logic core_supply_ok_i,
  input wire logic pin_above_vih_i,
  input wire logic [CH_NUM-1:0] output_channel_supply_i,
  input wire logic xo_clk_ok_i,
  input wire logic startup_mode_select_i,
  // Status.
  output srsq_pkg::srsq_state_t state_o,
  output logic [CH_NUM-1:0] ch_reset_o,
  output logic [CH_NUM-1:0] ch_mute_o,
  output logic cal_busy_o,
  output logic startup_mode_o
);
  import srsq_pkg::*;

  // Two-stage synchronisers for every asynchronous level.
  logic [CH_NUM+4:0] meta_ff;
  logic [CH_NUM+4:0] sync_ff;
  wire [CH_NUM+4:0] async_in = {startup_mode_select_i,
    output_channel_supply_i, xo_clk_ok_i, pin_above_vih_i,
    core_supply_ok_i, lnk.power_down_in_n};
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end
  wire pdn_s = sync_ff[0];
  wire core_ok_s = sync_ff[1];
  wire vih_s = sync_ff[2];
  wire xo_ok_s = sync_ff[3];
  wire [CH_NUM-1:0] vddo_s = sync_ff[CH_NUM+3:4];
  wire mode_s = sync_ff[CH_NUM+4];

  srsq_state_t state_ff;
  srsq_state_t nxt_state;
  logic [`SRSQ_TMO_W-1:0] cnt_ff;
  logic [`SRSQ_TMO_W-1:0] nxt_cnt;
  logic mode_ff;

  // Start-up follows the level, so supplies that arrive after the pin
  // rises still start the sequence instead of waiting for a new edge.
  wire power_good = core_ok_s && vih_s && pdn_s;
  wire por_done = (cnt_ff == `SRSQ_TMO_W'(`SRSQ_POR_CYC - 1));
  wire cal_done = (cnt_ff == `SRSQ_TMO_W'(`SRSQ_CAL_CYC - 1));
  wire lock_done = (cnt_ff == `SRSQ_TMO_W'(`SRSQ_LOCK_CYC - 1));
  wire [`SRSQ_TMO_W-1:0] cnt_next = cnt_ff + `SRSQ_TMO_W'(1);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_next;
    case (state_ff)
      SRSQ_OFF:
      begin
        nxt_cnt = '0;
        if (power_good)
          nxt_state = SRSQ_POR;
      end
      SRSQ_POR:
      begin
        if (por_done)
        begin
          nxt_state = SRSQ_XO_WAIT;
          nxt_cnt = '0;
        end
      end
      SRSQ_XO_WAIT:
      begin
        nxt_cnt = '0;
        if (xo_ok_s)
          nxt_state = SRSQ_CAL;
      end
      SRSQ_CAL:
      begin
        if (!xo_ok_s)
        begin
          nxt_state = SRSQ_XO_WAIT;
          nxt_cnt = '0;
        end
        else if (cal_done)
        begin
          nxt_state = SRSQ_LOCK;
          nxt_cnt = '0;
        end
      end
      SRSQ_LOCK:
      begin
        if (!xo_ok_s)
        begin
          nxt_state = SRSQ_XO_WAIT;
          nxt_cnt = '0;
        end
        else if (lock_done)
          nxt_state = SRSQ_RUN;
      end
      SRSQ_RUN:
      begin
        nxt_cnt = '0;
        if (lnk.soft_reset)
          nxt_state = SRSQ_XO_WAIT;
      end
      default:
      begin
        nxt_state = SRSQ_OFF;
        nxt_cnt = '0;
      end
    endcase
    if (!power_good)
    begin
      nxt_state = SRSQ_OFF;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_ff <= SRSQ_OFF;
      cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // The strap is caught when power-on reset begins.
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mode_ff <= 1'b0;
    else if (state_ff == SRSQ_OFF && nxt_state == SRSQ_POR)
      mode_ff <= mode_s;
  end

  // Per-channel release timers.
  wire dev_run = (state_ff == SRSQ_RUN);
  logic [`SRSQ_TMO_W-1:0] ch_cnt_ff [CH_NUM];
  logic [CH_NUM-1:0] ch_rst_ff;
  logic [CH_NUM-1:0] ch_mute_ff;
  for (genvar g = 0; g < CH_NUM; g++)
  begin : g_ch
    wire ch_exp = (ch_cnt_ff[g] == CH_TMO);
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        ch_cnt_ff[g] <= '0;
        ch_rst_ff[g] <= 1'b1;
        ch_mute_ff[g] <= 1'b1;
      end
      else if (!dev_run || !vddo_s[g])
      begin
        ch_cnt_ff[g] <= '0;
        ch_rst_ff[g] <= 1'b1;
        ch_mute_ff[g] <= 1'b1;
      end
      else if (!ch_exp)
      begin
        ch_cnt_ff[g] <= ch_cnt_ff[g] + `SRSQ_TMO_W'(1);
      end
      else
      begin
        ch_rst_ff[g] <= 1'b0;
        ch_mute_ff[g] <= ch_rst_ff[g];
      end
    end
  end

  // Status registers for the link and for cal_busy_o.
  logic xo_stable_ff;
  logic serial_en_ff;
  logic locked_ff;
  logic cal_busy_ff;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      xo_stable_ff <= 1'b0;
      serial_en_ff <= 1'b0;
      locked_ff <= 1'b0;
      cal_busy_ff <= 1'b0;
    end
    else
    begin
      xo_stable_ff <= xo_ok_s && (nxt_state != SRSQ_OFF);
      serial_en_ff <= (nxt_state != SRSQ_OFF);
      locked_ff <= (nxt_state == SRSQ_RUN);
      cal_busy_ff <= (nxt_state == SRSQ_CAL);
    end
  end
  assign lnk.xo_stable = xo_stable_ff;
  assign lnk.serial_enable = serial_en_ff;
  assign lnk.pll_locked = locked_ff;
  assign state_o = state_ff;
  assign ch_reset_o = ch_rst_ff;
  assign ch_mute_o = ch_mute_ff;
  assign cal_busy_o = cal_busy_ff;
  assign startup_mode_o = mode_ff;
endmodule

// >>> design/srsq_host.sv
// Purpose: Host end: drives power-down and soft reset for the device.
// Assumes: The host sees its own supplies settled as a level.
// Notes: Power-down pulses last longer than the device's capture time.
`timescale 1ns/10ps
`include "srsq_cfg.svh"
module srsq_host #(
  parameter int SETTLE_CYC = `SRSQ_HOST_SETTLE_CYC
)
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Link to the device.
  srsq_if.host lnk,
  // User side.
  input wire logic supplies_settled_i,
  input wire logic hard_reset_req_i,
  input wire logic soft_reset_req_i,
  output logic device_ready_o,
  output logic busy_o
);
  import srsq_pkg::*;

  logic meta_ff;
  logic sync_ff;
  logic pdn_ff;
  logic soft_ff;
  logic [31:0] cnt_ff;
  logic ready_ff;
  logic busy_ff;

  wire settled_s = sync_ff;
  // Oscillator status comes from logic on this clock, so it is used as is.
  wire xo_s = lnk.xo_stable;
  wire low_done = (cnt_ff >= 32'(`SRSQ_PDN_LOW_CYC));
  wire settle_done = (cnt_ff >= 32'(SETTLE_CYC));

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= supplies_settled_i;
      sync_ff <= meta_ff;
    end
  end

  // Power-down stays low until supplies settle, then for the settle time
  // and at least the minimum pulse width, so slow ramps postpone calibration.
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pdn_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else if (hard_reset_req_i || !settled_s)
    begin
      pdn_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else if (!pdn_ff)
    begin
      cnt_ff <= cnt_ff + 32'd1;
      if (low_done && settle_done)
        pdn_ff <= 1'b1;
    end
  end

  // Soft reset is a one-cycle pulse, only once the oscillator is stable.
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      soft_ff <= 1'b0;
      ready_ff <= 1'b0;
      busy_ff <= 1'b1;
    end
    else
    begin
      soft_ff <= soft_reset_req_i && xo_s && pdn_ff && !soft_ff;
      ready_ff <= lnk.pll_locked;
      busy_ff <= !pdn_ff;
    end
  end

  assign lnk.power_down_in_n = pdn_ff;
  assign lnk.soft_reset = soft_ff;
  assign device_ready_o = ready_ff;
  assign busy_o = busy_ff;
endmodule

// >>> sim/srsq_chk.sv
// Purpose: Assertions on the link between host and device.
// Assumes: One clock; reset is asynchronous and active high.
// Notes: Sees the interface signals only.
`timescale 1ns/10ps
module srsq_chk
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Link signals.
  input wire logic power_down_in_n,
  input wire logic soft_reset,
  input wire logic xo_stable,
  input wire logic serial_enable,
  input wire logic pll_locked
);
  logic [4:0] low_cnt_ff;
  logic [4:0] nxt_low_cnt;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Counts how long the power-down line has stayed low, saturating.
  assign nxt_low_cnt = power_down_in_n ? 5'h00 :
    ((low_cnt_ff == 5'h1f) ? low_cnt_ff : low_cnt_ff + 5'h01);
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      low_cnt_ff <= 5'h00;
    else
      low_cnt_ff <= nxt_low_cnt;
  end
  property p_pdn_width;
    $rose(power_down_in_n) |-> low_cnt_ff >= 5'h0b;
  endproperty
  a_pdn_width: assert property (p_pdn_width)
    else $error("power-down low pulse too short");
  property p_pdn_off;
    !power_down_in_n [*6] |-> !serial_enable;
  endproperty
  a_pdn_off: assert property (p_pdn_off)
    else $error("serial port on while powered down");
  property p_pdn_start;
    $rose(power_down_in_n) |-> ##[1:8] serial_enable;
  endproperty
  a_pdn_start: assert property (p_pdn_start)
    else $error("start-up did not follow power-down release");
  property p_lock_en;
    pll_locked |-> serial_enable;
  endproperty
  a_lock_en: assert property (p_lock_en)
    else $error("locked while device disabled");
  property p_soft_drop;
    soft_reset && pll_locked |=> !pll_locked;
  endproperty
  a_soft_drop: assert property (p_soft_drop)
    else $error("soft reset did not drop lock");
  property p_soft_xo;
    soft_reset |-> xo_stable;
  endproperty
  a_soft_xo: assert property (p_soft_xo)
    else $error("soft reset before oscillator stable");
  property p_lock_xo;
    $rose(pll_locked) |-> xo_stable;
  endproperty
  a_lock_xo: assert property (p_lock_xo)
    else $error("lock without stable oscillator");
  property p_relock;
    $fell(pll_locked) |=> !pll_locked [*8];
  endproperty
  a_relock: assert property (p_relock)
    else $error("lock returned without recalibration");
endmodule

// >>> sim/test_startup_reset_sequencer.sv
// Purpose: Self-checking bench for both ends of the sequencer.
// Assumes: Settle count 20 and channel timeout 4 for a short run.
// Notes: Channels 4 to 7 start without supply; only channel 4 gets it late, and 5 to 7 never do.
`timescale 1ns/10ps
module test_startup_reset_sequencer;
  import srsq_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] ch_sup = 8'h0f;
  logic mode_sel = 1'b0;
  logic hard_req = 1'b0;
  logic soft_req = 1'b0;
  logic settled = 1'b1;
  logic core_ok = 1'b1;
  logic xo_ok = 1'b1;
  logic ready;
  logic busy;
  srsq_state_t state;
  logic [7:0] ch_rst;
  logic [7:0] ch_mute;
  logic cal_busy;
  logic mode;
  int errors = 0;
  int checks_done = 0;
  srsq_if lnk();
  srsq_host #(.SETTLE_CYC(20)) u_srsq_host
  (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk.host),
    .supplies_settled_i(settled), .hard_reset_req_i(hard_req),
    .soft_reset_req_i(soft_req), .device_ready_o(ready), .busy_o(busy)
  );
  srsq_device #(.CH_NUM(8), .CH_TMO(16'h0004)) u_srsq_device
  (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk.dev),
    .core_supply_ok_i(core_ok), .pin_above_vih_i(1'b1),
    .output_channel_supply_i(ch_sup), .xo_clk_ok_i(xo_ok),
    .startup_mode_select_i(mode_sel), .state_o(state),
    .ch_reset_o(ch_rst), .ch_mute_o(ch_mute), .cal_busy_o(cal_busy),
    .startup_mode_o(mode)
  );
  srsq_chk u_srsq_chk
  (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .power_down_in_n(lnk.power_down_in_n), .soft_reset(lnk.soft_reset),
    .xo_stable(lnk.xo_stable), .serial_enable(lnk.serial_enable),
    .pll_locked(lnk.pll_locked)
  );
  always #10 core_clk_i = ~core_clk_i;
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic flag(input int k);
    case (k)
      0: flag = ready;
      1: flag = cal_busy;
      default: flag = !lnk.serial_enable;
    endcase
  endfunction
  // Waits, bounded, until the selected status is high.
  task automatic wt(input int k);
    int n;
    n = 0;
    // Step off the edge so outputs launched there have settled.
    #1;
    while (flag(k) !== 1'b1 && n < 400)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk("wait", {7'h00, flag(k)}, 8'h01);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    wt(0);
    chk("late", {ch_rst[7:4], ch_mute[7:4]}, 8'hff);
    chk("strap0", {7'h00, mode}, 8'h00);
    cyc(12);
    chk("early", {ch_rst[3:0], ch_mute[3:0]}, 8'h00);
    @(posedge core_clk_i);
    ch_sup[4] <= 1'b1;
    cyc(3);
    chk("ch4_hold", {7'h00, ch_rst[4]}, 8'h01);
    cyc(12);
    chk("ch_split", {ch_rst[7:4], ch_mute[7:4]}, 8'hee);
    $display("test channels done");
    @(posedge core_clk_i);
    core_ok <= 1'b0;
    wt(2);
    chk("core_off", {5'h00, state}, {5'h00, SRSQ_OFF});
    @(posedge core_clk_i);
    core_ok <= 1'b1;
    wt(0);
    $display("test supply loss done");
    @(posedge core_clk_i);
    soft_req <= 1'b1;
    wt(1);
    chk("soft_drop", {7'h00, ready}, 8'h00);
    chk("soft_ch", ch_rst, 8'hff);
    @(posedge core_clk_i);
    soft_req <= 1'b0;
    xo_ok <= 1'b0;
    cyc(4);
    chk("xo_wait", {5'h00, state}, {5'h00, SRSQ_XO_WAIT});
    @(posedge core_clk_i);
    xo_ok <= 1'b1;
    wt(1);
    wt(0);
    $display("test soft reset done");
    @(posedge core_clk_i);
    mode_sel <= 1'b1;
    hard_req <= 1'b1;
    wt(2);
    cyc(1);
    chk("off", {5'h00, state}, {5'h00, SRSQ_OFF});
    @(posedge core_clk_i);
    hard_req <= 1'b0;
    settled <= 1'b0;
    cyc(30);
    chk("settle_hold", {6'h00, busy, lnk.power_down_in_n}, 8'h02);
    @(posedge core_clk_i);
    settled <= 1'b1;
    wt(0);
    chk("strap", {7'h00, mode}, 8'h01);
    chk("busy_end", {7'h00, busy}, 8'h00);
    $display("test hard reset done");
    close_out();
  end
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    errors++;
    close_out();
  end
endmodule
